//--- common/vrt_defs.vh
// Constants for the video raster timing generator: register map, field
// positions, reset values and raster counts.
// Assumes one master clock; every count below is in nanoseconds, master-clock cycles, raster states or half-lines.
`ifndef VRT_DEFS_VH
`define VRT_DEFS_VH

// Master clock and derived rates
`define VRT_CLK_NS 100
`define VRT_PAUSE_NS 1000
`define VRT_PAUSE_CYC ((`VRT_PAUSE_NS) / (`VRT_CLK_NS))
`define VRT_PH_LAST 5'd19
`define VRT_PA_FIRST 5'd0
`define VRT_PA_LAST 5'd8
`define VRT_Q_FIRST 5'd5
`define VRT_Q_LAST 5'd14
`define VRT_E_FIRST 5'd10
`define VRT_E_LAST 5'd18
`define VRT_PIX_SLOT 5'd5
`define VRT_PIXEL_CLOCK_OUT_HIGH 5'd3
`define VRT_SC_MSB 2

// Horizontal raster states
`define VRT_HS_LAST_NORM 7'd90
`define VRT_HS_LAST_EARLY 7'd89
`define VRT_HS_ACTIVE 7'd64
`define VRT_HS_HALF 7'd45
`define VRT_HBLANK_FIRST 7'd70
`define VRT_HSYNC_FIRST 7'd72
`define VRT_HSYNC_LAST 7'd78
`define VRT_EQ_FIRST 7'd27
`define VRT_EQ_LAST 7'd29
`define VRT_SERR_FIRST 7'd20
`define VRT_SERR_LAST 7'd26

// Half-line (vertical) counts
`define VRT_HL_LAST_2TO1 10'd524
`define VRT_HL_LAST_1TO1 10'd523
`define VRT_HL_EQ1_LAST 10'd5
`define VRT_HL_VS_FIRST 10'd6
`define VRT_HL_VS_LAST 10'd11
`define VRT_HL_EQ2_LAST 10'd17
`define VRT_HL_VBLANK_LAST 10'd41

// Register map (byte addresses within the slave)
`define VRT_REG_SWITCH 8'h00
`define VRT_REG_STATUS 8'h04
`define VRT_REG_BORDER 8'h08
`define VRT_REG_LUT_BASE 8'h40
`define VRT_LUT_SEL_MASK 8'hc0

// Fields
`define VRT_SW_EXT 0
`define VRT_SW_S21 1
`define VRT_SW_NHS 2
`define VRT_SWITCH_RST 3'h7
`define VRT_ST_HB 6
`define VRT_ST_VB 7
`define VRT_ST_HSM_LSB 8
`define VRT_ST_HL_LSB 16
`define VRT_BORDER_RST 12'h000

`endif

//--- logic/vrt_raster_gen.v
// Video raster timing generator: bus clocks, pixel clock, colour subcarrier,
// horizontal raster states, sync and blanking, pixel colour output.
// Assumes ref_clk is the master clock, all inputs synchronous to it, and an AHB-Lite master.
`timescale 1ns/1ps
`include "vrt_defs.vh"

// Functional notes
// [R1] Subcarrier is master clock divided by eight, restarted at each sync falling edge.
// [R2] Sync pin carries composite sync when external sync is 0, else horizontal sync; low active.
// [R3] Internal composite sync has serration and equalization; 2:1 or 1:1 interlace by select.
// [R4] External mode: normal line timing when normal select is 1, early timing when 0.
// [R5] Vertical sync pin is input at reset and in external mode, output in internal mode.
// [R6] Two-phase non-overlapping internal clock at half the master clock rate.
// [R7] Two-phase non-overlapping clock at one twentieth rate; one phase drives E.
// [R8] Q runs at E frequency, in quadrature and leading E.
// [R9] Pixel clock gives four pulses per bus cycle, aligned with colour and transparency.
// [R10] Each colour output takes a 4-bit level from the lookup table entry.
// [R11] Transparency follows the pixel code's top bit; other bits ignored.
// [R12] Transparency is forced high throughout composite blanking.
// [R13] Horizontal state advances once per E period.
// [R14] Normal timing: 91 states, 0 to 90.
// [R15] Early timing: 90 states, 0 to 89.
// [R16] First 64 states clock out 256 pixels, four per state.
// [R17] States decode to sync, border-and-blanking, blanking, serration and equalization.
// [R18] Outside active pixels the border colour shows, except during horizontal blanking; black also shows during vertical blanking.
// [R19] Low-active border-and-blanking flag is status bit 6.
// [R20] Horizontal machine produces an increment for the vertical machine.
// [R21] Master clock may pause up to 1 us; logic holds state while stopped.
// [R22] Vertical increment fires twice per line.
// [R23] Internal mode drives vertical blanking onto the vertical sync pin.
// [R24] After its last state the horizontal machine wraps to 0.
module vrt_raster_gen (
  input wire ref_clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  input wire [15:0] pixelWord,
  input wire vsyncIn,
  output reg vsyncOut,
  output reg vsyncOe,
  output reg eClkOut,
  output reg qClkOut,
  output reg lowPhaseA,
  output reg intPhase1,
  output reg intPhase2,
  output reg pixelClockOut,
  output reg colorSubcarrierOut,
  output reg compSyncOut_n,
  output reg [3:0] redOut,
  output reg [3:0] greenOut,
  output reg [3:0] blueOut,
  output reg transparencyOut,
  output reg vsmIncrement,
  output reg [6:0] hsmState
);

  function inRange7;
    input [6:0] v;
    input [6:0] lo;
    input [6:0] hi;
    begin
      inRange7 = (v >= lo) && (v <= hi);
    end
  endfunction

  function inRange5;
    input [4:0] v;
    input [4:0] lo;
    input [4:0] hi;
    begin
      inRange5 = (v >= lo) && (v <= hi);
    end
  endfunction

  function inRange10;
    input [9:0] v;
    input [9:0] lo;
    input [9:0] hi;
    begin
      inRange10 = (v >= lo) && (v <= hi);
    end
  endfunction

  function [1:0] pixIndex;
    input [4:0] ph;
    begin
      if (ph >= 3 * `VRT_PIX_SLOT) begin
        pixIndex = 2'd3;
      end else if (ph >= 2 * `VRT_PIX_SLOT) begin
        pixIndex = 2'd2;
      end else if (ph >= `VRT_PIX_SLOT) begin
        pixIndex = 2'd1;
      end else begin
        pixIndex = 2'd0;
      end
    end
  endfunction

  reg [2:0] switch_r;
  reg [11:0] border_r;
  reg [11:0] lut_r [0:15];
  reg [4:0] phase_r;
  reg [9:0] halfLine_r;
  reg [2:0] scCnt_r;
  reg [15:0] pixWord_r;
  reg dispActive_r;
  reg dispBlank_r;
  reg vsyncPrev_r;
  reg wrPend_r;
  reg [7:0] wrAddr_r;

  wire extSel = switch_r[`VRT_SW_EXT];
  wire s21Sel = switch_r[`VRT_SW_S21];
  wire nhsSel = switch_r[`VRT_SW_NHS];

  // Master-clock phase within one E period
  wire periodEnd = (phase_r == `VRT_PH_LAST);
  wire [4:0] phaseNxt = periodEnd ? 5'd0 : phase_r + 5'd1;

  // Horizontal state machine
  wire [6:0] hsLast = nhsSel ? `VRT_HS_LAST_NORM : `VRT_HS_LAST_EARLY; // R14 R15 R4
  wire [6:0] hsmStep = (hsmState >= hsLast) ? 7'd0 : hsmState + 7'd1; // R24
  wire [6:0] hsm_nxt = periodEnd ? hsmStep : hsmState; // R13
  wire halfLineTick = periodEnd && ((hsmStep == 7'd0) || (hsmStep == `VRT_HS_HALF)); // R20 R22

  wire [9:0] hlLast = s21Sel ? `VRT_HL_LAST_2TO1 : `VRT_HL_LAST_1TO1; // R3
  wire extVsClear = extSel && vsyncPrev_r && !vsyncIn;
  reg [9:0] halfLine_nxt;
  always @* begin
    halfLine_nxt = halfLine_r;
    if (extVsClear) begin
      halfLine_nxt = 10'd0;
    end else if (halfLineTick) begin
      halfLine_nxt = (halfLine_r >= hlLast) ? 10'd0 : halfLine_r + 10'd1;
    end
  end

  // State decodes
  wire [6:0] relState = (hsmState >= `VRT_HS_HALF) ? hsmState - `VRT_HS_HALF : hsmState;
  wire hSyncPulse = inRange7(hsmState, `VRT_HSYNC_FIRST, `VRT_HSYNC_LAST); // R17
  wire eqPulse = inRange7(relState, `VRT_EQ_FIRST, `VRT_EQ_LAST); // R17
  wire serrLow = !inRange7(relState, `VRT_SERR_FIRST, `VRT_SERR_LAST); // R17
  wire hBlank = (hsmState >= `VRT_HBLANK_FIRST); // R17
  wire hBorderBlank_n = (hsmState < `VRT_HS_ACTIVE); // R17 R16
  wire eqZone = (halfLine_r <= `VRT_HL_EQ1_LAST) ||
    inRange10(halfLine_r, `VRT_HL_VS_LAST + 10'd1, `VRT_HL_EQ2_LAST);
  wire vsZone = inRange10(halfLine_r, `VRT_HL_VS_FIRST, `VRT_HL_VS_LAST);
  wire vBlank = (halfLine_r <= `VRT_HL_VBLANK_LAST);

  reg syncLow;
  always @* begin
    if (extSel) begin
      syncLow = hSyncPulse; // R2
    end else if (vsZone) begin
      syncLow = serrLow; // R3
    end else if (eqZone) begin
      syncLow = eqPulse; // R3
    end else begin
      syncLow = hSyncPulse; // R2
    end
  end

  // Subcarrier divider restarts on the sync falling edge
  wire syncFall = compSyncOut_n && syncLow;
  wire [2:0] scCnt_nxt = syncFall ? 3'd0 : scCnt_r + 3'd1; // R1

  // Pixel pipeline: the word sampled at a period end is shown during the next period
  wire [15:0] pixSrc = periodEnd ? pixelWord : pixWord_r;
  wire activeSrc = periodEnd ? hBorderBlank_n : dispActive_r;
  wire blankSrc = periodEnd ? (hBlank || vBlank) : dispBlank_r;
  wire [1:0] pixIdx = pixIndex(phaseNxt);
  wire [4:0] pixOff = phaseNxt - {1'b0, pixIdx, 2'b00} - {3'b000, pixIdx};

  reg [3:0] pixCode;
  always @* begin
    case (pixIdx)
      2'd0: pixCode = pixSrc[15:12];
      2'd1: pixCode = pixSrc[11:8];
      2'd2: pixCode = pixSrc[7:4];
      2'd3: pixCode = pixSrc[3:0];
      default: pixCode = 4'h0;
    endcase
  end

  reg [11:0] rgbNxt;
  reg xparNxt;
  always @* begin
    if (blankSrc) begin
      rgbNxt = 12'h000;
      xparNxt = 1'b1; // R12
    end else if (!activeSrc) begin
      rgbNxt = border_r; // R18
      xparNxt = 1'b0;
    end else begin
      rgbNxt = lut_r[pixCode]; // R10
      xparNxt = pixCode[3]; // R11
    end
  end

  // Raster counters; nothing here depends on elapsed time, so a stopped clock only freezes it
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      // Phase rests at the period end so every derived clock starts with a whole pulse
      phase_r <= `VRT_PH_LAST;
      hsmState <= 7'd0;
      halfLine_r <= 10'd0;
      vsyncPrev_r <= 1'b1;
      vsmIncrement <= 1'b0;
    end else begin // R21
      phase_r <= phaseNxt;
      hsmState <= hsm_nxt;
      halfLine_r <= halfLine_nxt;
      vsyncPrev_r <= vsyncIn;
      vsmIncrement <= halfLineTick; // R20 R22
    end
  end

  // Internal two-phase clock toggles freely; the bus clocks and pixel clock are decoded from the phase count
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      intPhase1 <= 1'b0;
      intPhase2 <= 1'b0;
      lowPhaseA <= 1'b0;
      eClkOut <= 1'b0;
      qClkOut <= 1'b0;
      pixelClockOut <= 1'b0;
    end else begin
      intPhase1 <= !intPhase1; // R6
      intPhase2 <= intPhase1; // R6
      lowPhaseA <= inRange5(phaseNxt, `VRT_PA_FIRST, `VRT_PA_LAST); // R7
      eClkOut <= inRange5(phaseNxt, `VRT_E_FIRST, `VRT_E_LAST); // R7
      qClkOut <= inRange5(phaseNxt, `VRT_Q_FIRST, `VRT_Q_LAST); // R8
      pixelClockOut <= (pixOff < `VRT_PIXEL_CLOCK_OUT_HIGH); // R9
    end
  end

  // Sync output and the subcarrier divider locked to it
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      scCnt_r <= 3'd0;
      colorSubcarrierOut <= 1'b0;
      compSyncOut_n <= 1'b1;
    end else begin
      scCnt_r <= scCnt_nxt;
      colorSubcarrierOut <= scCnt_nxt[`VRT_SC_MSB]; // R1
      compSyncOut_n <= !syncLow; // R2
    end
  end

  // Vertical sync pin: released in external mode so the far side may drive it
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      vsyncOut <= 1'b1;
      vsyncOe <= 1'b0;
    end else begin
      vsyncOe <= !extSel; // R5
      vsyncOut <= !vBlank; // R23
    end
  end

  // Pixel pipeline and colour outputs
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pixWord_r <= 16'h0000;
      dispActive_r <= 1'b0;
      dispBlank_r <= 1'b1;
      redOut <= 4'h0;
      greenOut <= 4'h0;
      blueOut <= 4'h0;
      transparencyOut <= 1'b1;
    end else begin
      if (periodEnd) begin
        pixWord_r <= pixelWord; // R16
        dispActive_r <= hBorderBlank_n;
        dispBlank_r <= hBlank || vBlank;
      end
      redOut <= rgbNxt[11:8];
      greenOut <= rgbNxt[7:4];
      blueOut <= rgbNxt[3:0];
      transparencyOut <= xparNxt;
    end
  end

  // AHB-Lite slave, zero wait states
  wire addrPhase = hsel && htrans[1] && hready;

  // LUT window decode, shared by the read mux and the write strobe
  function isLutAddr;
    input [7:0] a;
    begin
      isLutAddr = ((a & `VRT_LUT_SEL_MASK) == `VRT_REG_LUT_BASE);
    end
  endfunction

  function [31:0] readMux;
    input [7:0] a;
    input [2:0] sw;
    input [11:0] bd;
    input [11:0] lutVal;
    input hb;
    input vb;
    input [6:0] hs;
    input [9:0] hl;
    begin
      readMux = 32'h0000_0000;
      if (a == `VRT_REG_SWITCH) begin
        readMux[2:0] = sw;
      end else if (a == `VRT_REG_STATUS) begin
        readMux[`VRT_ST_HB] = hb; // R19
        readMux[`VRT_ST_VB] = vb;
        readMux[`VRT_ST_HSM_LSB +: 7] = hs;
        readMux[`VRT_ST_HL_LSB +: 10] = hl;
      end else if (a == `VRT_REG_BORDER) begin
        readMux[11:0] = bd;
      end else if (isLutAddr(a)) begin
        readMux[11:0] = lutVal;
      end
    end
  endfunction

  wire [7:0] rdAddr = haddr[7:0];
  wire wrSwitch = wrPend_r && (wrAddr_r == `VRT_REG_SWITCH);
  wire wrBorder = wrPend_r && (wrAddr_r == `VRT_REG_BORDER);
  wire wrLut = wrPend_r && isLutAddr(wrAddr_r);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend_r <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_r <= haddr[7:0];
      end
      if (addrPhase && !hwrite) begin
        hrdata <= readMux(rdAddr, switch_r, border_r, lut_r[rdAddr[5:2]], hBorderBlank_n, !vBlank,
          hsmState, halfLine_r);
      end
    end
  end

  // Writes land at the end of the data phase, when hwdata stands
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      switch_r <= `VRT_SWITCH_RST;
      border_r <= `VRT_BORDER_RST;
    end else begin
      if (wrSwitch) begin
        switch_r <= hwdata[2:0];
      end
      if (wrBorder) begin
        border_r <= hwdata[11:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_lut
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          lut_r[gi] <= 12'h000;
        end else if (wrLut && (wrAddr_r[5:2] == gi)) begin
          lut_r[gi] <= hwdata[11:0];
        end
      end
    end
  endgenerate

endmodule // vrt_raster_gen

//--- bench/vrt_raster_gen_props.sv
// Checker for the raster generator: bus clocks, raster steps, blanking, sync lock.
// Assumes the generator's own ports only; bound at the foot of this file.
`timescale 1ns/1ps
module vrt_raster_props (
  input wire ref_clk,
  input wire rst_n,
  input wire lowPhaseA,
  input wire eClkOut,
  input wire qClkOut,
  input wire intPhase1,
  input wire intPhase2,
  input wire pixelClockOut,
  input wire colorSubcarrierOut,
  input wire compSyncOut_n,
  input wire [3:0] redOut,
  input wire [3:0] greenOut,
  input wire [3:0] blueOut,
  input wire transparencyOut,
  input wire vsmIncrement,
  input wire [6:0] hsmState
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_hsmStep;
    $changed(hsmState) |-> $rose(lowPhaseA) ##1 $stable(hsmState)[*8];
  endproperty
  a_hsmStep: assert property (p_hsmStep) else $error("state step spacing wrong");
  property p_hsmNext;
    $changed(hsmState) |-> (hsmState == $past(hsmState) + 7'd1 && hsmState <= 7'd90) ||
      (hsmState == 7'd0 && $past(hsmState) >= 7'd89);
  endproperty
  a_hsmNext: assert property (p_hsmNext) else $error("state sequence wrong");
  property p_eWidth;
    $rose(eClkOut) |=> eClkOut[*8] ##1 !eClkOut;
  endproperty
  a_eWidth: assert property (p_eWidth) else $error("E high time wrong");
  property p_qLead;
    $rose(qClkOut) |-> !eClkOut ##5 $rose(eClkOut);
  endproperty
  a_qLead: assert property (p_qLead) else $error("Q does not lead E");
  property p_phase;
    intPhase1 |-> !intPhase2 ##1 (!intPhase1 && intPhase2);
  endproperty
  a_phase: assert property (p_phase) else $error("internal phases overlap");
  property p_pixel_clock_out;
    $rose(pixelClockOut) |=> pixelClockOut[*2] ##1 !pixelClockOut[*2] ##1 pixelClockOut;
  endproperty
  a_pixel_clock_out: assert property (p_pixel_clock_out) else $error("pixel clock shape wrong");
  property p_subc;
    $fell(compSyncOut_n) |-> ##[2:5] $rose(colorSubcarrierOut);
  endproperty
  a_subc: assert property (p_subc) else $error("subcarrier not locked to sync");
  property p_blank;
    hsmState >= 7'd72 |-> transparencyOut && {redOut, greenOut, blueOut} == 12'h000;
  endproperty
  a_blank: assert property (p_blank) else $error("blanking not applied");
  property p_vsmInc;
    vsmIncrement |-> (hsmState == 7'd0 || hsmState == 7'd45) ##1 !vsmIncrement;
  endproperty
  a_vsmInc: assert property (p_vsmInc) else $error("vertical increment misplaced");
  c_wrapNorm: cover property (hsmState == 7'd0 && $past(hsmState) == 7'd90);
  c_wrapEarly: cover property (hsmState == 7'd0 && $past(hsmState) == 7'd89);
  c_vsm: cover property (vsmIncrement);
  c_sync: cover property ($fell(compSyncOut_n));
endmodule // vrt_raster_props

bind vrt_raster_gen vrt_raster_props u_props (.ref_clk, .rst_n, .lowPhaseA, .eClkOut, .qClkOut, .intPhase1,
  .intPhase2, .pixelClockOut, .colorSubcarrierOut, .compSyncOut_n, .redOut, .greenOut, .blueOut,
  .transparencyOut, .vsmIncrement, .hsmState);

//--- bench/vrt_monitor_model.sv
// Far-side monitor: measures sync period and pulse width, resolves the vertical sync pin.
// Assumes sync is sampled on the generator's clock.
`timescale 1ns/1ps
module vrt_monitor_model (
  input wire ref_clk,
  input wire compSyncOut_n,
  input wire vsyncOut,
  input wire vsyncOe,
  input wire vsPulse,
  output wire vsyncIn,
  output reg [15:0] linePeriod,
  output reg [15:0] syncWidth
);
  reg [15:0] cnt = 16'h0000;
  reg [15:0] lowCnt = 16'h0000;
  reg prevSync = 1'b1;
  // Pin has a pull-up; the far side pulls it low only while vsPulse is high and the pin is released
  assign vsyncIn = vsyncOe ? vsyncOut : !vsPulse;
  always @(posedge ref_clk) begin
    prevSync <= compSyncOut_n;
    cnt <= cnt + 16'h0001;
    if (prevSync && !compSyncOut_n) begin
      linePeriod <= cnt;
      cnt <= 16'h0001;
    end
    if (!compSyncOut_n) lowCnt <= lowCnt + 16'h0001;
    else if (lowCnt != 16'h0000) begin
      syncWidth <= lowCnt;
      lowCnt <= 16'h0000;
    end
  end
endmodule // vrt_monitor_model

//--- bench/testbench.sv
// Self-checking bench for the raster generator: bus access, line timing, pixel path.
// Assumes the generator is the only bus slave and the monitor model sits on its video side.
`timescale 1ns/1ps
`include "vrt_defs.vh"
module testbench;
  reg ref_clk = 0;
  reg rst_n = 0;
  reg hold = 0;
  reg hsel = 0;
  reg [31:0] haddr = 0;
  reg [1:0] htrans = 0;
  reg hwrite = 0;
  reg [31:0] hwdata = 0;
  reg [15:0] pixelWord = 0;
  reg rdTake = 0;
  reg pixOn = 0;
  reg vsPulse = 0;
  wire hreadyout, hresp, vsyncIn, vsyncOut, vsyncOe, transparencyOut, compSyncOut_n;
  wire [31:0] hrdata;
  wire [3:0] redOut, greenOut, blueOut;
  wire [6:0] hsmState;
  wire [15:0] linePeriod, syncWidth;
  integer miscompares = 0;
  integer checked = 0;
  integer seed = 47667;
  integer i, k, off;
  reg [63:0] rdQ[$];
  reg [12:0] pixQ[$];
  reg [11:0] lut[0:15];
  reg [11:0] border;
  reg [63:0] e;
  reg [31:0] lastRd;
  reg [15:0] w;
  reg [3:0] c;
  reg [6:0] drvPrev = 0;
  reg [6:0] monPrev = 0;
  reg armed = 0;
  reg wasOn = 0;

  vrt_raster_gen i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pixelWord(pixelWord), .vsyncIn(vsyncIn), .vsyncOut(vsyncOut),
    .vsyncOe(vsyncOe), .eClkOut(), .qClkOut(), .lowPhaseA(), .intPhase1(), .intPhase2(),
    .pixelClockOut(), .colorSubcarrierOut(), .compSyncOut_n(compSyncOut_n), .redOut(redOut),
    .greenOut(greenOut), .blueOut(blueOut), .transparencyOut(transparencyOut), .vsmIncrement(),
    .hsmState(hsmState));
  vrt_monitor_model i_mon (.ref_clk(ref_clk), .compSyncOut_n(compSyncOut_n), .vsyncOut(vsyncOut),
    .vsyncOe(vsyncOe), .vsPulse(vsPulse), .vsyncIn(vsyncIn), .linePeriod(linePeriod), .syncWidth(syncWidth));

  initial begin
    forever begin
      #50;
      if (!hold) ref_clk = ~ref_clk;
    end
  end

  task check(input string what, input [31:0] seen, input [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task busReq(input [7:0] a, input wr);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'b00;
  endtask

  task wr(input [7:0] a, input [31:0] d);
    busReq(a, 1'b1);
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
  endtask

  task rd(input [7:0] a, input [31:0] exp, input [31:0] mask);
    rdQ.push_back({mask, exp});
    busReq(a, 1'b0);
    rdTake <= 1;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    lastRd = hrdata;
    rdTake <= 0;
  endtask

  // Driver: new pixel word each raster state, expected colours noted per pixel
  always @(posedge ref_clk) begin
    if (hsmState !== drvPrev) begin
      drvPrev = hsmState;
      if (pixOn) begin
        w = $random(seed);
        pixelWord <= w;
        for (k = 0; k < 4; k = k + 1) begin
          c = w[15 - 4 * k -: 4];
          pixQ.push_back(drvPrev < `VRT_HS_ACTIVE ? {c[3], lut[c]} :
            drvPrev < `VRT_HBLANK_FIRST ? {1'b0, border} : {1'b1, 12'h000});
        end
      end
    end
  end

  // Monitor: read data and mid-pixel colour samples against the oldest notes
  always @(posedge ref_clk) begin
    if (rdTake && hreadyout) begin
      e = rdQ.pop_front();
      check("hrdata", hrdata & e[63:32], e[31:0]);
    end
    if (hsmState !== monPrev) begin
      monPrev = hsmState;
      off = 0;
      armed = wasOn;
      wasOn = pixOn;
    end else off = off + 1;
    if (armed && off % 5 == 2) check("pixel", {transparencyOut, redOut, greenOut, blueOut}, pixQ.pop_front());
  end

  initial begin
    #(80000 * 100);
    miscompares = miscompares + 1;
    finish_test;
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    check("vsyncOe", vsyncOe, 0);
    rd(`VRT_REG_SWITCH, 32'h7, '1);
    rd(8'h3c, 32'h0, '1);
    border = $random(seed);
    wr(`VRT_REG_BORDER, border);
    rd(`VRT_REG_BORDER, border, '1);
    for (i = 0; i < 16; i = i + 1) begin
      lut[i] = $random(seed);
      wr(8'(`VRT_REG_LUT_BASE + 4 * i), lut[i]);
      rd(8'(`VRT_REG_LUT_BASE + 4 * i), lut[i], '1);
    end
    repeat (500) @(posedge ref_clk);
    hold = 1;
    #1000;
    hold = 0;
    repeat (3 * 1820) @(posedge ref_clk);
    check("line", linePeriod, 91 * 20);
    check("hsync", syncWidth, 7 * 20);
    wr(`VRT_REG_SWITCH, 32'h3);
    repeat (3 * 1820) @(posedge ref_clk);
    check("early", linePeriod, 90 * 20);
    vsPulse <= 1;
    @(posedge ref_clk);
    vsPulse <= 0;
    rd(`VRT_REG_STATUS, 32'h0, 32'h03ff_0000);
    wr(`VRT_REG_SWITCH, 32'h6);
    repeat (2) @(posedge ref_clk);
    check("vsyncOe", vsyncOe, 1);
    do begin
      rd(`VRT_REG_STATUS, 32'h0, 32'h0);
      check("hb", lastRd[6], lastRd[14:8] < 7'd64);
      check("vsync", vsyncIn, lastRd[7]);
      repeat (97) @(posedge ref_clk);
    end while (lastRd[25:16] < 10'd44);
    pixOn <= 1;
    repeat (2 * 1820) @(posedge ref_clk);
    pixOn <= 0;
    repeat (60) @(posedge ref_clk);
    check("left", pixQ.size(), 0);
    finish_test;
  end
endmodule // testbench
